// *** pkg/dscid_pkg.sv ***
// Package: constants and types for the instruction fetch and decode block
package dscid_pkg;
   // Program counter
   localparam logic [22:0] PC_RESET = 23'h000000;
   localparam logic [22:0] PC_STEP = 23'h000002;
   localparam logic [22:0] PC_STEP2 = 23'h000004;
   // Opcode classes
   localparam logic [7:0] OP_NOP = 8'h00;
   localparam logic [7:0] OP_IND = 8'h01;
   localparam logic [7:0] OP_CALL_DW = 8'h02;
   localparam logic [7:0] OP_GOTO_DW = 8'h04;
   localparam logic [7:0] OP_DO_DW = 8'h08;
   localparam logic [7:0] OP_RETURN = 8'h06;
   localparam logic [7:0] OP_INTR_RET = 8'h07;
   localparam logic [7:0] OP_CBR_LO = 8'h30;
   localparam logic [7:0] OP_CBR_HI = 8'h36;
   localparam logic [7:0] OP_BRANCH = 8'h37;
   localparam logic [7:0] OP_TBL_LO = 8'hBA;
   localparam logic [7:0] OP_TBL_HI = 8'hBB;
   localparam logic [7:0] OP_MOVD = 8'hBE;
   localparam logic [7:0] OP_SKIP_LO = 8'hE6;
   localparam logic [7:0] OP_SKIP_HI = 8'hE7;
   // Stall lengths in clocks (two clocks per instruction cycle)
   localparam logic [2:0] STALL_TWO = 3'h2;
   localparam logic [2:0] STALL_THREE = 3'h4;
   // Field positions in the first word
   localparam int P_OPC = 16;
   localparam int P_WID = 14;
   localparam int P_SHD = 13;
   localparam int P_LIT = 4;
   localparam int P_BASE = 10;
   localparam int P_DMODE = 7;
   localparam int P_DREG = 3;
   localparam int P_ACC = 15;
   localparam int P_AWB = 13;
   localparam int P_MPR = 10;
   localparam int P_XPF = 7;
   localparam int P_YPF = 4;
   localparam int P_XD = 2;
   // Width qualifier, dest mode and write-back encodings
   localparam logic [1:0] WID_WORD = 2'h0;
   localparam logic [1:0] WID_BYTE = 2'h1;
   localparam logic [1:0] WID_DWORD = 2'h2;
   localparam logic [2:0] DM_DIRECT = 3'h0;
   localparam logic [2:0] DM_RSVD = 3'h7;
   localparam logic [1:0] AWB_NONE = 2'h0;
   localparam logic [1:0] AWB_RSVD = 2'h3;
   localparam logic [1:0] AWB_POSTINC = 2'h2;
   // Register byte addresses and reset values
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_PC = 8'h08;
   localparam logic [7:0] A_WORD = 8'h0C;
   localparam logic [7:0] A_COUNT = 8'h10;
   localparam logic RUN_RESET = 1'b0;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_FETCH = 3'b001, S_DECODE = 3'b011,
      S_FETCH2 = 3'b010, S_DECODE2 = 3'b110, S_STALL = 3'b111,
      S_PEEK = 3'b101, S_PEEKCHK = 3'b100
   } dscid_state_t;

   typedef struct packed {
      logic c, dc, n, ov, z, oa, ob, sa, sb;
   } dscid_flags_t;

   typedef struct packed {
      logic [7:0] opcode;
      logic dword;
      logic [1:0] width;
      logic shadow;
      logic [12:0] file_addr;
      logic file_op_working_reg;
      logic [3:0] base_operand_reg;
      logic [2:0] dest_mode;
      logic [3:0] dest_operand_reg;
      logic [3:0] bit_index_field;
      logic [9:0] lit10;
      logic [15:0] signed_ten_bit_literal;
      logic [15:0] slit16;
      logic acc_b;
      logic [1:0] mac_writeback_target;
      logic [2:0] mpair, xpref, ypref;
      logic [1:0] xdest, ydest;
      logic [22:0] program_address_literal;
      logic enc_err;
   } dscid_dec_t;

   typedef struct packed {
      dscid_state_t st;
      logic run;
      logic [22:0] pc;
      logic [23:0] w1;
      logic [2:0] cnt;
      logic pm_rd;
      logic [22:0] pm_addr;
      logic exec;
      logic nop;
      dscid_dec_t dec;
      dscid_flags_t flg;
      logic err;
      logic [15:0] count;
      logic [31:0] rdata;
   } dscid_state_s_t;
endpackage

// *** design/dscid_decoder.sv ***
// Module: instruction fetch sequencer, field decoder and status flags
`timescale 1ns/1ps
`default_nettype none
module dscid_decoder (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Program memory
   output logic pm_rd,
   output logic [22:0] pm_addr,
   input wire logic [23:0] pm_data,
   // Datapath
   input wire logic cond_true,
   input wire logic [22:0] jump_target,
   input wire logic flag_upd,
   input wire dscid_pkg::dscid_flags_t flag_mask,
   input wire dscid_pkg::dscid_flags_t flag_val,
   output logic exec_valid,
   output logic nop_cycle,
   output dscid_pkg::dscid_dec_t dec,
   output dscid_pkg::dscid_flags_t flags
);
   dscid_pkg::dscid_state_s_t q;
   dscid_pkg::dscid_state_s_t next_q;

   function automatic logic in_rng(input logic [7:0] v, input logic [7:0] lo,
                                   input logic [7:0] hi);
      in_rng = (v >= lo) && (v <= hi);
   endfunction

   function automatic logic is_dw(input logic [7:0] o);
      is_dw = (o == dscid_pkg::OP_CALL_DW) || (o == dscid_pkg::OP_GOTO_DW) ||
              (o == dscid_pkg::OP_DO_DW);
   endfunction

   // Field decode of one or two words
   function automatic dscid_pkg::dscid_dec_t decode(input logic [23:0] a,
                                                    input logic [23:0] b,
                                                    input logic dw);
      dscid_pkg::dscid_dec_t d;
      logic [1:0] wd;
      d = '0;
      wd = a[dscid_pkg::P_WID +: 2];
      d.opcode = a[dscid_pkg::P_OPC +: 8];
      d.dword = dw;
      d.width = (wd == 2'h3) ? dscid_pkg::WID_WORD : wd;
      d.shadow = a[dscid_pkg::P_SHD];
      d.file_addr = a[12:0];
      d.file_op_working_reg = a[dscid_pkg::P_SHD];
      d.base_operand_reg = a[dscid_pkg::P_BASE +: 4];
      d.dest_mode = a[dscid_pkg::P_DMODE +: 3];
      if (d.dest_mode == dscid_pkg::DM_RSVD) begin
         d.dest_mode = dscid_pkg::DM_DIRECT;
      end
      d.dest_operand_reg = a[dscid_pkg::P_DREG +: 4];
      d.bit_index_field = a[3:0];
      if (d.width == dscid_pkg::WID_BYTE) begin
         d.lit10 = {2'h0, a[dscid_pkg::P_LIT +: 8]};
      end else begin
         d.lit10 = a[dscid_pkg::P_LIT +: 10];
      end
      d.signed_ten_bit_literal = {{6{a[13]}}, a[dscid_pkg::P_LIT +: 10]};
      d.slit16 = a[15:0];
      d.acc_b = a[dscid_pkg::P_ACC];
      d.mac_writeback_target = a[dscid_pkg::P_AWB +: 2];
      if (d.mac_writeback_target == dscid_pkg::AWB_RSVD) begin
         d.mac_writeback_target = dscid_pkg::AWB_NONE;
      end
      d.mpair = a[dscid_pkg::P_MPR +: 3];
      d.xpref = a[dscid_pkg::P_XPF +: 3];
      d.ypref = a[dscid_pkg::P_YPF +: 3];
      d.xdest = a[dscid_pkg::P_XD +: 2];
      d.ydest = a[1:0];
      d.program_address_literal = {b[6:0], a[15:1], 1'b0};
      d.enc_err = dw && (a[0] || (b[23:16] != 8'h00));
      decode = d;
   endfunction

   logic [7:0] opc;
   logic [7:0] peek_opc;
   assign opc = pm_data[23:16];
   assign peek_opc = pm_data[23:16];

   always_comb begin
      next_q = q;
      next_q.pm_rd = 1'b0;
      next_q.exec = 1'b0;
      next_q.nop = (q.st == dscid_pkg::S_STALL) || (q.st == dscid_pkg::S_PEEK) ||
                   (q.st == dscid_pkg::S_PEEKCHK);
      next_q.rdata = 32'h00000000;
      unique case (q.st)
         dscid_pkg::S_IDLE: begin
            if (q.run) begin
               next_q.pm_rd = 1'b1;
               next_q.pm_addr = q.pc;
               next_q.st = dscid_pkg::S_FETCH;
            end
         end
         dscid_pkg::S_FETCH: begin
            next_q.st = dscid_pkg::S_DECODE;
         end
         dscid_pkg::S_DECODE: begin
            next_q.w1 = pm_data;
            next_q.st = dscid_pkg::S_STALL;
            next_q.cnt = 3'h0;
            if (is_dw(opc)) begin
               next_q.pm_rd = 1'b1;
               next_q.pm_addr = q.pc + dscid_pkg::PC_STEP;
               next_q.st = dscid_pkg::S_FETCH2;
            end else begin
               next_q.exec = 1'b1;
               next_q.dec = decode(pm_data, 24'h000000, 1'b0);
               next_q.pc = q.pc + dscid_pkg::PC_STEP;
               if (opc == dscid_pkg::OP_BRANCH || opc == dscid_pkg::OP_IND) begin
                  next_q.pc = jump_target;
                  next_q.cnt = dscid_pkg::STALL_TWO;
               end else if (opc == dscid_pkg::OP_RETURN ||
                            opc == dscid_pkg::OP_INTR_RET) begin
                  next_q.pc = jump_target;
                  next_q.cnt = dscid_pkg::STALL_THREE;
               end else if (in_rng(opc, dscid_pkg::OP_TBL_LO, dscid_pkg::OP_TBL_HI) ||
                            opc == dscid_pkg::OP_MOVD) begin
                  next_q.cnt = dscid_pkg::STALL_TWO;
               end else if (in_rng(opc, dscid_pkg::OP_CBR_LO, dscid_pkg::OP_CBR_HI) &&
                            cond_true) begin
                  next_q.pc = jump_target;
                  next_q.cnt = dscid_pkg::STALL_TWO;
               end else if (in_rng(opc, dscid_pkg::OP_SKIP_LO, dscid_pkg::OP_SKIP_HI) &&
                            cond_true) begin
                  next_q.pm_rd = 1'b1;
                  next_q.pm_addr = q.pc + dscid_pkg::PC_STEP;
                  next_q.st = dscid_pkg::S_PEEK;
               end
               if (next_q.st == dscid_pkg::S_STALL && next_q.cnt == 3'h0) begin
                  next_q.st = dscid_pkg::S_IDLE;
                  if (q.run) begin
                     next_q.pm_rd = 1'b1;
                     next_q.pm_addr = next_q.pc;
                     next_q.st = dscid_pkg::S_FETCH;
                  end
               end
            end
         end
         dscid_pkg::S_FETCH2: begin
            next_q.st = dscid_pkg::S_DECODE2;
         end
         dscid_pkg::S_DECODE2: begin
            next_q.exec = 1'b1;
            next_q.dec = decode(q.w1, pm_data, 1'b1);
            next_q.err = q.err | next_q.dec.enc_err;
            next_q.pc = q.pc + dscid_pkg::PC_STEP2;
            if (q.w1[23:16] == dscid_pkg::OP_GOTO_DW ||
                q.w1[23:16] == dscid_pkg::OP_CALL_DW) begin
               next_q.pc = next_q.dec.program_address_literal;
            end
            next_q.st = dscid_pkg::S_IDLE;
            if (q.run) begin
               next_q.pm_rd = 1'b1;
               next_q.pm_addr = next_q.pc;
               next_q.st = dscid_pkg::S_FETCH;
            end
         end
         dscid_pkg::S_PEEK: begin
            next_q.st = dscid_pkg::S_PEEKCHK;
         end
         dscid_pkg::S_PEEKCHK: begin
            if (is_dw(peek_opc)) begin
               next_q.pc = q.pc + dscid_pkg::PC_STEP2;
               next_q.cnt = dscid_pkg::STALL_TWO;
               next_q.st = dscid_pkg::S_STALL;
            end else begin
               next_q.pc = q.pc + dscid_pkg::PC_STEP;
               next_q.st = dscid_pkg::S_IDLE;
               if (q.run) begin
                  next_q.pm_rd = 1'b1;
                  next_q.pm_addr = next_q.pc;
                  next_q.st = dscid_pkg::S_FETCH;
               end
            end
         end
         dscid_pkg::S_STALL: begin
            next_q.cnt = q.cnt - 3'h1;
            if (q.cnt == 3'h1) begin
               next_q.st = dscid_pkg::S_IDLE;
               if (q.run) begin
                  next_q.pm_rd = 1'b1;
                  next_q.pm_addr = q.pc;
                  next_q.st = dscid_pkg::S_FETCH;
               end
            end
         end
      endcase
      if (next_q.exec) begin
         next_q.count = q.count + 16'h0001;
      end
      // Register writes
      if (reg_wr && reg_addr == dscid_pkg::A_CTRL) begin
         next_q.run = reg_wdata[0];
      end
      if (reg_wr && reg_addr == dscid_pkg::A_PC && q.st == dscid_pkg::S_IDLE) begin
         next_q.pc = {reg_wdata[22:1], 1'b0};
      end
      if (reg_wr && reg_addr == dscid_pkg::A_STATUS) begin
         next_q.flg = reg_wdata[8:0];
         next_q.err = reg_wdata[9];
      end
      // Datapath flag updates win over a software write
      if (flag_upd) begin
         if (flag_mask.c) next_q.flg.c = flag_val.c;
         if (flag_mask.dc) next_q.flg.dc = flag_val.dc;
         if (flag_mask.n) next_q.flg.n = flag_val.n;
         if (flag_mask.ov) next_q.flg.ov = flag_val.ov;
         if (flag_mask.z) next_q.flg.z = flag_val.z;
         if (!q.dec.acc_b && flag_mask.oa) next_q.flg.oa = flag_val.oa;
         if (q.dec.acc_b && flag_mask.ob) next_q.flg.ob = flag_val.ob;
         if (!q.dec.acc_b && flag_mask.sa && flag_val.sa) next_q.flg.sa = 1'b1;
         if (q.dec.acc_b && flag_mask.sb && flag_val.sb) next_q.flg.sb = 1'b1;
      end
      if (next_q.exec && next_q.dec.enc_err) begin
         next_q.err = 1'b1;
      end
      // Register reads
      if (reg_rd) begin
         unique case (reg_addr)
            dscid_pkg::A_CTRL: next_q.rdata = {31'h00000000, q.run};
            dscid_pkg::A_STATUS: next_q.rdata = {22'h000000, q.err, q.flg};
            dscid_pkg::A_PC: next_q.rdata = {9'h000, q.pc};
            dscid_pkg::A_WORD: next_q.rdata = {8'h00, q.w1};
            dscid_pkg::A_COUNT: next_q.rdata = {16'h0000, q.count};
            default: next_q.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         q <= '0;
         q.st <= dscid_pkg::S_IDLE;
         q.run <= dscid_pkg::RUN_RESET;
         q.pc <= dscid_pkg::PC_RESET;
      end else begin
         q <= next_q;
      end
   end

   assign reg_rdata = q.rdata;
   assign pm_rd = q.pm_rd;
   assign pm_addr = q.pm_addr;
   assign exec_valid = q.exec;
   assign nop_cycle = q.nop;
   assign dec = q.dec;
   assign flags = q.flg;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   sequence dw_fetch_s;
      (q.st == dscid_pkg::S_FETCH2) ##1 (q.st == dscid_pkg::S_DECODE2);
   endsequence
   sequence dw_exec_s;
      exec_valid && dec.dword;
   endsequence

   a_opcode_top: assert property (exec_valid && !dec.dword |->
      dec.opcode == q.w1[23:16]) else $error("opcode not top byte");
   a_dword_pair: assert property (dw_fetch_s |=> dw_exec_s)
      else $error("double word not decoded after second fetch");
   a_second_nop: assert property (exec_valid && dec.opcode == dscid_pkg::OP_NOP |->
      !dec.dword ##1 !nop_cycle) else $error("lone second word not a nop");
   a_cbr_taken: assert property (exec_valid && q.run && $past(cond_true) &&
      in_rng(dec.opcode, dscid_pkg::OP_CBR_LO, dscid_pkg::OP_CBR_HI) |->
      ##1 nop_cycle[*2] ##2 (exec_valid || q.st == dscid_pkg::S_FETCH2 || !q.run))
      else $error("taken branch cost wrong");
   a_return_cost: assert property (exec_valid && q.run &&
      dec.opcode == dscid_pkg::OP_RETURN |->
      ##1 nop_cycle[*4] ##2 (exec_valid || q.st == dscid_pkg::S_FETCH2 || !q.run))
      else $error("return not three cycles");
   a_skip_cost: assert property (exec_valid && q.run && $past(cond_true) &&
      in_rng(dec.opcode, dscid_pkg::OP_SKIP_LO, dscid_pkg::OP_SKIP_HI) |->
      ##1 nop_cycle[*2] ##2 (exec_valid || nop_cycle || q.st == dscid_pkg::S_FETCH2 || !q.run))
      else $error("skip cost wrong");
   a_dword_time: assert property (dw_exec_s and (q.st == dscid_pkg::S_FETCH) |->
      ##2 (exec_valid || q.st == dscid_pkg::S_FETCH2))
      else $error("double word not two cycles");
   a_lit_even: assert property (dw_exec_s |->
      dec.program_address_literal[0] == 1'b0) else $error("odd address");
   a_byte_lit: assert property (exec_valid && dec.width == dscid_pkg::WID_BYTE |->
      dec.lit10 <= 10'h0FF) else $error("byte literal above 255");
   a_sat_sticky: assert property (flags.sa && !reg_wr |=> flags.sa)
      else $error("saturation flag dropped");
   a_pc_past_both: assert property (q.st == dscid_pkg::S_FETCH2 &&
      q.w1[23:16] == dscid_pkg::OP_DO_DW |-> ##2 (pm_rd || !q.run) &&
      q.pc == $past(pm_addr, 2) + dscid_pkg::PC_STEP)
      else $error("pc not past both words");
   a_exec_pulse: assert property (exec_valid |=> !exec_valid)
      else $error("execute pulse longer than one clock");
   a_fetch_pulse: assert property (pm_rd |=> !pm_rd)
      else $error("fetch pulse longer than one clock");
   a_file_addr: assert property (exec_valid |->
      dec.file_addr == q.w1[12:0]) else $error("file address field misplaced");
   a_base_reg: assert property (exec_valid |->
      dec.base_operand_reg == q.w1[13:10]) else $error("base register field misplaced");
   a_bit_index: assert property (exec_valid |->
      dec.bit_index_field == q.w1[3:0]) else $error("bit index field misplaced");
   a_dest_legal: assert property (exec_valid |->
      dec.dest_mode != dscid_pkg::DM_RSVD) else $error("reserved destination mode");
   a_awb_legal: assert property (exec_valid |->
      dec.mac_writeback_target != dscid_pkg::AWB_RSVD) else $error("reserved write-back");
   a_width_legal: assert property (exec_valid |->
      dec.width != 2'h3) else $error("reserved width code");
   a_flag_apply: assert property (flag_upd && flag_mask.c |->
      ##1 flags.c == $past(flag_val.c)) else $error("carry update lost");
   a_acc_gate: assert property (flag_upd && !dec.acc_b && !reg_wr |=>
      $stable(flags.ob)) else $error("accumulator B flag changed for A");
endmodule
`default_nettype wire

// *** sim/dscid_pm_model.sv ***
// Program memory and datapath responder model for the decoder bench
`timescale 1ns/1ps
`default_nettype none
module dscid_pm_model (
   // Clock
   input wire logic ref_clk,
   // Fetch port
   input wire logic pm_rd,
   input wire logic [22:0] pm_addr,
   output logic [23:0] pm_data,
   // Datapath answers
   output logic cond_true,
   output logic [22:0] jump_target
);
   logic [23:0] mem [0:63];
   logic cond_pat [0:63];
   initial pm_data = 24'h000000;
   // Word valid one cycle after a read, scrambled at all other times
   always @(posedge ref_clk) begin
      if (pm_rd)
         pm_data <= mem[pm_addr[6:1]];
      else
         pm_data <= ~pm_data;
   end
   // Test result and branch target follow the word being fetched
   assign cond_true = cond_pat[pm_addr[6:1]];
   assign jump_target = pm_addr + 23'h000004;
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the instruction fetch and decode block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic ref_clk, srst, reg_wr, reg_rd, flag_upd, pm_rd, cond_true, exec_valid, nop_cycle;
   logic [7:0] reg_addr, op;
   logic [31:0] reg_wdata, reg_rdata, rd_val;
   logic [22:0] pm_addr, jump_target, epc, np;
   logic [23:0] pm_data, w1;
   logic [8:0] eflg, m, v, mm;
   dscid_pkg::dscid_flags_t flag_mask, flag_val, flags;
   dscid_pkg::dscid_dec_t dec, e, x;
   int bad_count, cmp_count, cyc, n_exec, gap, egap, c, nopc, enop, snap;
   logic [7:0] ops [0:15] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h06, 8'h07, 8'h30,
      8'h34, 8'h36, 8'h37, 8'hBA, 8'hBB, 8'hBE, 8'hE6, 8'hE7};
   logic [7:0] regs [0:5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};

   dscid_decoder uut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_data(pm_data), .cond_true(cond_true),
      .jump_target(jump_target), .flag_upd(flag_upd), .flag_mask(flag_mask),
      .flag_val(flag_val), .exec_valid(exec_valid), .nop_cycle(nop_cycle), .dec(dec),
      .flags(flags));
   dscid_pm_model pmem (.ref_clk(ref_clk), .pm_rd(pm_rd), .pm_addr(pm_addr),
      .pm_data(pm_data), .cond_true(cond_true), .jump_target(jump_target));

   always #25 ref_clk = ~ref_clk;

   task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   function automatic logic is_dw(input logic [7:0] o);
      return o == dscid_pkg::OP_CALL_DW || o == dscid_pkg::OP_GOTO_DW || o == dscid_pkg::OP_DO_DW;
   endfunction

   function automatic dscid_pkg::dscid_dec_t exp_dec(input logic [23:0] a, input logic [23:0] b);
      dscid_pkg::dscid_dec_t d;
      d = '0;
      d.opcode = a[23:16];
      d.dword = is_dw(a[23:16]);
      d.width = (a[15:14] == 2'h3) ? dscid_pkg::WID_WORD : a[15:14];
      d.shadow = a[13];
      d.file_addr = a[12:0];
      d.file_op_working_reg = a[13];
      d.base_operand_reg = a[13:10];
      d.dest_mode = (a[9:7] == dscid_pkg::DM_RSVD) ? dscid_pkg::DM_DIRECT : a[9:7];
      d.dest_operand_reg = a[6:3];
      d.bit_index_field = a[3:0];
      d.lit10 = (d.width == dscid_pkg::WID_BYTE) ? {2'h0, a[11:4]} : a[13:4];
      d.signed_ten_bit_literal = {{6{a[13]}}, a[13:4]};
      d.slit16 = a[15:0];
      d.acc_b = a[15];
      d.mac_writeback_target = (a[14:13] == dscid_pkg::AWB_RSVD) ? dscid_pkg::AWB_NONE : a[14:13];
      d.mpair = a[12:10];
      d.xpref = a[9:7];
      d.ypref = a[6:4];
      d.xdest = a[3:2];
      d.ydest = a[1:0];
      d.program_address_literal = {d.dword ? b[6:0] : 7'h00, a[15:1], 1'b0};
      d.enc_err = d.dword && (b[23:16] != 8'h00 || a[0]);
      return d;
   endfunction

   // Reference walk of the program, one step for each of the first 40 executed instructions
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc > 5000) begin
         bad_count++;
         complete_run();
      end
   end

   always @(posedge ref_clk) begin
      gap++;
      if (nop_cycle === 1'b1)
         nopc++;
      if (exec_valid === 1'b1) begin
         if (n_exec < 40) begin
            w1 = pmem.mem[epc[6:1]];
            op = w1[23:16];
            e = exp_dec(w1, pmem.mem[epc[6:1] + 6'h01]);
            x = dec;
            if (n_exec > 0) check("gap", gap, egap);
            if (n_exec > 0 && !e.dword) check("nop", nopc, enop);
            check("dec", x, e);
            c = 1;
            np = e.dword ? epc + 23'h4 : epc + 23'h2;
            if (op == dscid_pkg::OP_IND || op == dscid_pkg::OP_BRANCH) begin
               c = 2;
               np = epc + 23'h4;
            end
            else if (op == dscid_pkg::OP_RETURN || op == dscid_pkg::OP_INTR_RET) begin
               c = 3;
               np = epc + 23'h4;
            end
            else if (op >= dscid_pkg::OP_CBR_LO && op <= dscid_pkg::OP_CBR_HI && pmem.cond_pat[epc[6:1]]) begin
               c = 2;
               np = epc + 23'h4;
            end
            else if (op == dscid_pkg::OP_TBL_LO || op == dscid_pkg::OP_TBL_HI || op == dscid_pkg::OP_MOVD)
               c = 2;
            else if (op >= dscid_pkg::OP_SKIP_LO && op <= dscid_pkg::OP_SKIP_HI && pmem.cond_pat[epc[6:1]]) begin
               c = is_dw(pmem.mem[epc[6:1] + 6'h01][23:16]) ? 3 : 2;
               np = (c == 3) ? epc + 23'h6 : epc + 23'h4;
            end
            else if (op == dscid_pkg::OP_CALL_DW || op == dscid_pkg::OP_GOTO_DW)
               np = e.program_address_literal;
            egap = 2 * c + (is_dw(pmem.mem[np[6:1]][23:16]) ? 2 : 0);
            enop = 2 * (c - 1);
            epc = np;
         end
         n_exec++;
         gap = 0;
         nopc = 0;
      end
   end

   initial begin
      ref_clk = 1'b0;
      srst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h00000000;
      flag_upd = 1'b0;
      flag_mask = '0;
      flag_val = '0;
      bad_count = 0;
      cmp_count = 0;
      cyc = 0;
      n_exec = 0;
      gap = 0;
      nopc = 0;
      void'($urandom(17117));
      for (int j = 0; j < 64; j++)
         pmem.cond_pat[j] = 1'($urandom);
      for (int j = 0; j < 64; j++) begin
         op = ops[$urandom % 16];
         w1 = {op, 16'($urandom)};
         if (is_dw(op) && j < 63) begin
            w1[0] = 1'b0;
            pmem.mem[j + 1] = {17'h00000, 7'($urandom)};
         end
         else if (is_dw(op))
            w1[23:16] = dscid_pkg::OP_NOP;
         pmem.mem[j] = w1;
         if (is_dw(op) && j < 63)
            j++;
      end
      // Taken skip over a double-word at the start
      pmem.mem[8] = 24'hE60000;
      pmem.cond_pat[8] = 1'b1;
      pmem.mem[9] = 24'h040020;
      pmem.mem[10] = 24'h000000;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      reg_write(8'h14, 32'hFFFFFFFF);
      foreach (regs[j]) begin
         reg_read(regs[j], rd_val);
         check("reg reset", rd_val, 32'h00000000);
      end
      // Flag updates while accumulator A is selected
      eflg = 9'h000;
      repeat (24) begin
         m = 9'($urandom);
         v = 9'($urandom);
         mm = m & 9'h1F8;
         @(posedge ref_clk);
         flag_mask <= m;
         flag_val <= v;
         flag_upd <= 1'b1;
         @(posedge ref_clk);
         flag_upd <= 1'b0;
         eflg = (eflg & ~mm) | (v & mm);
         eflg[1] = eflg[1] | (m[1] & v[1]);
         #1 check("flags", flags, eflg);
      end
      reg_read(dscid_pkg::A_STATUS, rd_val);
      check("status", rd_val[8:0], eflg);
      reg_write(dscid_pkg::A_STATUS, 32'h00000000);
      reg_read(dscid_pkg::A_STATUS, rd_val);
      check("status clear", rd_val, 32'h00000000);
      reg_write(dscid_pkg::A_PC, 32'h00000011);
      reg_read(dscid_pkg::A_PC, rd_val);
      check("pc", rd_val, 32'h00000010);
      epc = 23'h10;
      reg_write(dscid_pkg::A_CTRL, 32'h00000001);
      for (int j = 0; j < 2000 && n_exec < 40; j++)
         @(posedge ref_clk);
      reg_write(dscid_pkg::A_CTRL, 32'h00000000);
      repeat (20) @(posedge ref_clk);
      snap = n_exec;
      repeat (20) @(posedge ref_clk);
      check("stopped", n_exec, snap);
      check("ran", n_exec >= 40, 1'b1);
      reg_read(dscid_pkg::A_COUNT, rd_val);
      check("count", rd_val, n_exec);
      complete_run();
   end
endmodule
`default_nettype wire
